// file: pgcs_consts.vh
// Purpose: Constants for the programming port control and status block.
// Assumes: Included by its bare name from every design file of the block.
// Notes:   Definitions only.
`ifndef PGCS_CONSTS_VH
`define PGCS_CONSTS_VH

// ==========================================================================
// Control-space offsets
`define PGCS_OFS_STATUS      4'h0
`define PGCS_OFS_GUARD       4'h2
`define PGCS_OFS_IDENT       4'hf

// ==========================================================================
// Field positions and reset values
`define PGCS_NVM_PROGRAMMING_ENABLED_BIT       1
`define PGCS_GUARD_MSB       2
`define PGCS_GUARD_RESET     3'h0
`define PGCS_STATUS_RESET    1'b0
// Identification code; the value is arbitrary.
`define PGCS_IDENT_CODE      8'h5a

// ==========================================================================
// Instruction opcodes
`define PGCS_OP_LOAD_HI      4'h8
`define PGCS_OP_STORE_HI     4'hc
`define PGCS_OP_KEY          8'he0
`define PGCS_KEY_BYTES       4'h8
`define PGCS_ENABLE_KEY      64'h1289ab45cdd888ff

// ==========================================================================
// Guard time
`define PGCS_GUARD_BASE_IDLE 8'h02
`define PGCS_GUARD_CNT_W     8

// ==========================================================================
// Memory map and sections
`define PGCS_NVM_BASE        16'h4000
`define PGCS_SEC_CODE        2'h0
`define PGCS_SEC_CONFIG      2'h1
`define PGCS_SEC_SIGNATURE   2'h2
`define PGCS_SEC_CALIB       2'h3

`endif

// file: pgcs_guard_timer.v
// Purpose: Counts idle bits on a receive-to-transmit turnaround.
// Assumes: One bit_tick pulse per link bit time.
// Notes:   A new start restarts the count.
`timescale 1ns/1ps
`include "pgcs_consts.vh"

module pgcs_guard_timer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  input  wire       bit_tick,
  input  wire [2:0] gt_sel,
  output reg        busy_q,
  output reg        done_q
);

  reg  [`PGCS_GUARD_CNT_W-1:0] cnt_q;
  reg  [`PGCS_GUARD_CNT_W-1:0] extra;
  wire [`PGCS_GUARD_CNT_W-1:0] total;

  // ========================================================================
  // Guard selection decode.
  always @* begin
    case (gt_sel)
      3'h0:    extra = 8'h80;
      3'h1:    extra = 8'h40;
      3'h2:    extra = 8'h20;
      3'h3:    extra = 8'h10;
      3'h4:    extra = 8'h08;
      3'h5:    extra = 8'h04;
      3'h6:    extra = 8'h02;
      default: extra = 8'h00;
    endcase
  end

  assign total = extra + `PGCS_GUARD_BASE_IDLE;

  // ========================================================================
  // Idle bit counter.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= total;
        busy_q <= 1'b1;
      end else if (busy_q && bit_tick) begin
        if (cnt_q == 8'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

endmodule // pgcs_guard_timer

// file: pgcs_prog_model.sv
// Purpose: External programmer driving the instruction port.
// Assumes: Load data answers exactly one cycle after the load.
// Notes:   Released lines carry the inverse of the last value.
`timescale 1ns/1ps
module pgcs_prog_model (
  input  wire       clk,
  input  wire [7:0] rdata,
  output reg        cmd_valid,
  output reg  [7:0] opcode,
  output reg  [7:0] data,
  output reg        key_valid,
  output reg  [7:0] key_byte
);
  integer i;
  initial begin
    cmd_valid = 1'b0;
    opcode    = 8'h00;
    data      = 8'h00;
    key_valid = 1'b0;
    key_byte  = 8'h00;
  end
  // One instruction byte for one cycle, control space only by load and store.
  task issue(input [7:0] op, input [7:0] dt);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      opcode    <= op;
      data      <= dt;
      @(posedge clk);
      cmd_valid <= 1'b0;
      opcode    <= ~op;
      data      <= ~dt;
    end
  endtask
  task cs_load(input [3:0] a, output [7:0] d);
    begin
      issue({4'h8, a}, 8'h00);
      #1 d = rdata;
    end
  endtask
  // Key bytes follow the key instruction, least significant first.
  task send_key(input [63:0] k);
    begin
      issue(8'he0, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
        key_valid <= 1'b1;
        key_byte  <= k[8*i +: 8];
        @(posedge clk);
      end
      key_valid <= 1'b0;
      key_byte  <= ~key_byte;
    end
  endtask
  // Status is polled until programming is enabled, at most eight loads.
  task poll(output [7:0] d);
    begin
      i = 0;
      d = 8'h00;
      while (i < 8 && d[1] !== 1'b1) begin
        cs_load(4'h0, d);
        i = i + 1;
      end
    end
  endtask
endmodule // pgcs_prog_model

// file: pgcs_sva.sv
// Purpose: Port-level assertions for pgcs_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound into every pgcs_top instance.
`timescale 1ns/1ps
module pgcs_sva (
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic        CMD_VALID,
  input wire logic [7:0]  CMD_OPCODE,
  input wire logic [7:0]  CS_RDATA,
  input wire logic        CS_RVALID,
  input wire logic        TURN_TO_TX,
  input wire logic        GUARD_ACTIVE,
  input wire logic        TX_START,
  input wire logic        CORE_LD_REQ,
  input wire logic [15:0] CORE_LD_ADDR,
  input wire logic        NVM_RD_DATA_SEL,
  input wire logic        CORE_STALL,
  input wire logic        PRG_NVM_WR_REQ,
  input wire logic [1:0]  PRG_SECTION,
  input wire logic        NVM_WR_EN,
  input wire logic        NVM_PRG_ENABLED
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // ========================================================================
  // Assertions
  load_answer_a: assert property (CMD_VALID && CMD_OPCODE[7:4] == 4'h8 |=> CS_RVALID)
    else $error("load not answered");
  ident_code_a: assert property (CMD_VALID && CMD_OPCODE == 8'h8f |=> CS_RDATA == 8'h5a)
    else $error("bad ident code");
  reserved_zero_a: assert property (CMD_VALID && CMD_OPCODE == 8'h81 |=> CS_RDATA == 8'h00)
    else $error("reserved offset not zero");
  turn_guard_a: assert property (TURN_TO_TX |=> GUARD_ACTIVE)
    else $error("guard not started");
  tx_after_guard_a: assert property (TX_START |-> $past(GUARD_ACTIVE) && !GUARD_ACTIVE)
    else $error("transmit without guard");
  load_first_a: assert property (CORE_LD_REQ && CORE_LD_ADDR >= 16'h4000
    |=> NVM_RD_DATA_SEL && CORE_STALL)
    else $error("data read not first");
  stall_data_a: assert property (CORE_STALL |-> NVM_RD_DATA_SEL)
    else $error("stall without data read");
  section_ro_a: assert property (PRG_NVM_WR_REQ && PRG_SECTION[1] |=> !NVM_WR_EN)
    else $error("read-only section written");
  wr_needs_key_a: assert property (PRG_NVM_WR_REQ && !NVM_PRG_ENABLED |=> !NVM_WR_EN)
    else $error("write while disabled");
  cover property (TX_START);
  cover property (NVM_WR_EN);
  cover property (CORE_STALL);
endmodule // pgcs_sva

bind pgcs_top pgcs_sva u_pgcs_sva (.*);

// file: pgcs_top.v
// Purpose: Control and status space of the serial programming port and
//          the access policy of the non-volatile memory controller.
// Assumes: All inputs synchronous to MCLK; command strobes are one cycle.
// Notes:   The rules that this block keeps are listed below.
// Contract
// - Control registers live apart from I/O space, reached only by control-space load/store.
// - Offset 0x0F returns a fixed 8-bit identification code.
// - Guard field at offset 0x02 bits 2:0 selects 128 down to 0 idle bits.
// - Guard bits are added only on receive-to-transmit turnaround.
// - Turnaround idle equals guard count plus two idle bits.
// - Guard setting resets to 128 extra idle bits.
// - Status offset 0x00 bit 1 reads one while programming is enabled.
// - Writing zero to the enable bit ends programming.
// - Flash powers down in sleep when no programming runs.
// - Memories map into data space, readable by core indirect loads.
// - Core data read served first; next fetch follows, stalling one cycle.
// - Core write or erase attempts to memory have no effect.
// - External mode programs all sections except signature and calibration.
// - Programming enables only after the matching 64-bit key.
// - Load opcode is 1000 aaaa, store is 1100 aaaa.
`timescale 1ns/1ps
`include "pgcs_consts.vh"

module pgcs_top (
  input  wire        MCLK,
  input  wire        RESET_N,
  input  wire        CMD_VALID,
  input  wire [7:0]  CMD_OPCODE,
  input  wire [7:0]  CMD_DATA,
  input  wire        KEY_BYTE_VALID,
  input  wire [7:0]  KEY_BYTE,
  output reg  [7:0]  CS_RDATA,
  output reg         CS_RVALID,
  input  wire        TURN_TO_TX,
  input  wire        BIT_TICK,
  output wire        GUARD_ACTIVE,
  output wire        TX_START,
  input  wire        CORE_SLEEP,
  input  wire        NVM_BUSY,
  output reg         FLASH_PWR_DOWN,
  input  wire        FETCH_REQ,
  input  wire [15:0] FETCH_ADDR,
  input  wire        CORE_LD_REQ,
  input  wire [15:0] CORE_LD_ADDR,
  output reg         NVM_RD,
  output reg         NVM_RD_DATA_SEL,
  output reg  [15:0] NVM_ADDR,
  output reg         CORE_STALL,
  input  wire        CORE_NVM_WR_REQ,
  input  wire        PRG_NVM_WR_REQ,
  input  wire [1:0]  PRG_SECTION,
  output reg         NVM_WR_EN,
  output reg         PRG_WR_REJECT,
  output reg         NVM_PRG_ENABLED
);

  // ========================================================================
  // State and decode signals.
  reg  [2:0]  guard_sel_q;
  reg  [2:0]  guard_sel_d;
  reg         nvm_en_q;
  reg         nvm_en_d;
  reg  [63:0] key_shift_q;
  reg  [3:0]  key_left_q;
  reg  [7:0]  rdata_d;
  wire        is_load;
  wire        is_store;
  wire        is_key;
  wire [3:0]  cs_addr;
  wire        key_last;
  wire [63:0] key_full;
  wire        key_match;
  wire        ld_mapped;
  wire        sec_read_only;

  assign cs_addr  = CMD_OPCODE[3:0];
  assign is_load  = CMD_VALID && (CMD_OPCODE[7:4] == `PGCS_OP_LOAD_HI);
  assign is_store = CMD_VALID && (CMD_OPCODE[7:4] == `PGCS_OP_STORE_HI);
  assign is_key   = CMD_VALID && (CMD_OPCODE == `PGCS_OP_KEY);

  // ========================================================================
  // Control-space read decode.
  always @* begin
    rdata_d = 8'h00;
    case (cs_addr)
      `PGCS_OFS_STATUS: begin
        rdata_d[`PGCS_NVM_PROGRAMMING_ENABLED_BIT] = nvm_en_q;
      end
      `PGCS_OFS_GUARD: begin
        rdata_d[`PGCS_GUARD_MSB:0] = guard_sel_q;
      end
      `PGCS_OFS_IDENT: begin
        rdata_d = `PGCS_IDENT_CODE;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CS_RDATA  <= 8'h00;
      CS_RVALID <= 1'b0;
    end else begin
      CS_RVALID <= is_load;
      if (is_load) begin
        CS_RDATA <= rdata_d;
      end
    end
  end

  // ========================================================================
  // Key collection.
  assign key_full  = {KEY_BYTE, key_shift_q[63:8]};
  assign key_last  = KEY_BYTE_VALID && (key_left_q == 4'h1);
  assign key_match = key_last && (key_full == `PGCS_ENABLE_KEY);

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      key_shift_q <= 64'h0;
      key_left_q  <= 4'h0;
    end else begin
      if (is_key) begin
        key_left_q <= `PGCS_KEY_BYTES;
      end else if (KEY_BYTE_VALID && (key_left_q != 4'h0)) begin
        key_shift_q <= key_full;
        key_left_q  <= key_left_q - 4'h1;
      end
    end
  end

  // ========================================================================
  // Control-space writes.
  always @* begin
    guard_sel_d = guard_sel_q;
    nvm_en_d    = nvm_en_q;
    if (is_store && (cs_addr == `PGCS_OFS_GUARD)) begin
      guard_sel_d = CMD_DATA[`PGCS_GUARD_MSB:0];
    end
    if (is_store && (cs_addr == `PGCS_OFS_STATUS) && !CMD_DATA[`PGCS_NVM_PROGRAMMING_ENABLED_BIT]) begin
      nvm_en_d = 1'b0;
    end
    if (key_match) begin
      nvm_en_d = 1'b1;
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      guard_sel_q     <= `PGCS_GUARD_RESET;
      nvm_en_q        <= `PGCS_STATUS_RESET;
      NVM_PRG_ENABLED <= 1'b0;
    end else begin
      guard_sel_q     <= guard_sel_d;
      nvm_en_q        <= nvm_en_d;
      NVM_PRG_ENABLED <= nvm_en_d;
    end
  end

  // ========================================================================
  // Turnaround guard; only the receive-to-transmit turn starts it.
  pgcs_guard_timer u_guard (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .start    (TURN_TO_TX),
    .bit_tick (BIT_TICK),
    .gt_sel   (guard_sel_q),
    .busy_q   (GUARD_ACTIVE),
    .done_q   (TX_START)
  );

  // ========================================================================
  // Flash power control.
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FLASH_PWR_DOWN <= 1'b0;
    end else begin
      FLASH_PWR_DOWN <= CORE_SLEEP && !NVM_BUSY && !NVM_WR_EN;
    end
  end

  // ========================================================================
  // Single read port arbitration.
  assign ld_mapped = CORE_LD_REQ && (CORE_LD_ADDR >= `PGCS_NVM_BASE);

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NVM_RD          <= 1'b0;
      NVM_RD_DATA_SEL <= 1'b0;
      NVM_ADDR        <= 16'h0000;
      CORE_STALL      <= 1'b0;
    end else begin
      CORE_STALL <= ld_mapped;
      if (ld_mapped) begin
        NVM_RD          <= 1'b1;
        NVM_RD_DATA_SEL <= 1'b1;
        NVM_ADDR        <= CORE_LD_ADDR - `PGCS_NVM_BASE;
      end else if (FETCH_REQ) begin
        NVM_RD          <= 1'b1;
        NVM_RD_DATA_SEL <= 1'b0;
        NVM_ADDR        <= FETCH_ADDR;
      end else begin
        NVM_RD          <= 1'b0;
        NVM_RD_DATA_SEL <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Write permission.
  assign sec_read_only = (PRG_SECTION == `PGCS_SEC_SIGNATURE) ||
                         (PRG_SECTION == `PGCS_SEC_CALIB);

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      NVM_WR_EN     <= 1'b0;
      PRG_WR_REJECT <= 1'b0;
    end else begin
      // Core write requests never reach the array.
      NVM_WR_EN     <= PRG_NVM_WR_REQ && nvm_en_q && !sec_read_only;
      PRG_WR_REJECT <= PRG_NVM_WR_REQ && (!nvm_en_q || sec_read_only);
    end
  end

  wire unused_core_wr;
  assign unused_core_wr = CORE_NVM_WR_REQ;

endmodule // pgcs_top

// file: programming_port_control_status_bench.sv
// Purpose: Self-checking bench for pgcs_top.
// Assumes: Programmer model drives the instruction port.
// Notes:   Each scenario checks its own results.
`timescale 1ns/1ps
module programming_port_control_status_bench;
  reg         MCLK = 1'b0;
  reg         RESET_N = 1'b0;
  reg         TURN_TO_TX = 1'b0, BIT_TICK = 1'b0, CORE_SLEEP = 1'b0, NVM_BUSY = 1'b0;
  reg         FETCH_REQ = 1'b0, CORE_LD_REQ = 1'b0, CORE_NVM_WR_REQ = 1'b0;
  reg         PRG_NVM_WR_REQ = 1'b0;
  reg  [15:0] FETCH_ADDR = 16'h0000, CORE_LD_ADDR = 16'h0000;
  reg  [1:0]  PRG_SECTION = 2'h0;
  wire        CMD_VALID, KEY_BYTE_VALID, CS_RVALID, GUARD_ACTIVE, TX_START, FLASH_PWR_DOWN;
  wire        NVM_RD, NVM_RD_DATA_SEL, CORE_STALL, NVM_WR_EN, PRG_WR_REJECT, NVM_PRG_ENABLED;
  wire [7:0]  CMD_OPCODE, CMD_DATA, KEY_BYTE, CS_RDATA;
  wire [15:0] NVM_ADDR;
  integer     fail_count = 0;
  integer     n_tests = 0;
  integer     k;
  reg  [7:0]  d;
  always #12.5 MCLK = ~MCLK;
  pgcs_top u_pgcs_top (.*);
  pgcs_prog_model u_pgcs_prog_model (.clk(MCLK), .rdata(CS_RDATA), .cmd_valid(CMD_VALID),
    .opcode(CMD_OPCODE), .data(CMD_DATA), .key_valid(KEY_BYTE_VALID), .key_byte(KEY_BYTE));
  task chk(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task ld(input [3:0] a);
    u_pgcs_prog_model.cs_load(a, d);
  endtask
  task st(input [3:0] a, input [7:0] v);
    u_pgcs_prog_model.issue({4'hc, a}, v);
  endtask
  task edge_req(input integer sel);
    begin
      @(posedge MCLK) PRG_NVM_WR_REQ <= (sel < 4);
      CORE_NVM_WR_REQ <= (sel == 4);
      PRG_SECTION <= sel[1:0];
      @(posedge MCLK) PRG_NVM_WR_REQ <= 1'b0;
      CORE_NVM_WR_REQ <= 1'b0;
      #1;
    end
  endtask
  // ==========================================================================
  // Scenarios
  task t_regs;
    begin
      ld(4'h0); chk("status", 8'h00, d);
      ld(4'h2); chk("guard", 8'h00, d);
      ld(4'hf); chk("ident", 8'h5a, d);
      chk("rvalid", 1, CS_RVALID);
      st(4'h1, 8'hff);
      #1 chk("rvalid", 0, CS_RVALID);
      ld(4'h1); chk("resv", 8'h00, d);
      st(4'h0, 8'h02); ld(4'h0); chk("status", 8'h00, d);
    end
  endtask
  task t_key;
    begin
      edge_req(0); chk("wr_en", 0, NVM_WR_EN);
      chk("reject", 1, PRG_WR_REJECT);
      u_pgcs_prog_model.send_key(64'h1289ab45cdd888fe);
      ld(4'h0); chk("status", 8'h00, d);
      u_pgcs_prog_model.send_key(64'h1289ab45cdd888ff);
      u_pgcs_prog_model.poll(d); chk("status", 8'h02, d);
      chk("enabled", 1, NVM_PRG_ENABLED);
      for (k = 0; k < 5; k = k + 1) begin
        edge_req(k); chk("wr_en", k < 2, NVM_WR_EN);
        chk("reject", k == 2 || k == 3, PRG_WR_REJECT);
      end
      st(4'h0, 8'h00); ld(4'h0); chk("status", 8'h00, d);
      chk("enabled", 0, NVM_PRG_ENABLED);
    end
  endtask
  // The last pass leaves the shortest guard time selected.
  task t_guard;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        st(4'h2, k[7:0]); ld(4'h2); chk("guard", k, d);
        @(posedge MCLK) TURN_TO_TX <= 1'b1;
        @(posedge MCLK) TURN_TO_TX <= 1'b0;
        @(posedge MCLK) BIT_TICK <= 1'b1;
        repeat ((k == 7 ? 0 : 128 >> k) + 1) @(posedge MCLK);
        #1 chk("active", 1, GUARD_ACTIVE);
        @(posedge MCLK) BIT_TICK <= 1'b0;
        #1 chk("tx_start", 1, TX_START);
      end
    end
  endtask
  task t_port;
    begin
      @(posedge MCLK) CORE_LD_REQ <= 1'b1;
      CORE_LD_ADDR <= 16'h4010;
      FETCH_REQ <= 1'b1;
      FETCH_ADDR <= 16'h0123;
      @(posedge MCLK) CORE_LD_REQ <= 1'b0;
      CORE_LD_ADDR <= 16'hbfef;
      #1 chk("nvm_addr", 16'h0010, NVM_ADDR);
      chk("stall", 3'h7, {NVM_RD, NVM_RD_DATA_SEL, CORE_STALL});
      @(posedge MCLK) FETCH_REQ <= 1'b0;
      #1 chk("fetch", 16'h0123, NVM_ADDR);
      chk("stall", 3'h4, {NVM_RD, NVM_RD_DATA_SEL, CORE_STALL});
    end
  endtask
  task t_power;
    begin
      @(posedge MCLK) CORE_SLEEP <= 1'b1;
      repeat (2) @(posedge MCLK);
      #1 chk("pwr_dn", 1, FLASH_PWR_DOWN);
      @(posedge MCLK) NVM_BUSY <= 1'b1;
      repeat (2) @(posedge MCLK);
      #1 chk("pwr_dn", 0, FLASH_PWR_DOWN);
    end
  endtask
  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    RESET_N <= 1'b1;
    t_regs;
    t_key;
    t_guard;
    t_port;
    t_power;
    results;
  end
  initial begin
    repeat (4000) @(posedge MCLK);
    fail_count = fail_count + 1;
    results;
  end
endmodule // programming_port_control_status_bench
